/* rtl/sram_boundary_scan_tap.sv */
`include "sram_tap_cfg.svh"
`default_nettype none

module sram_boundary_scan_tap #(
   parameter logic [`ID_LEN-1:0] ID_VALUE = 32'h0a5a_5001 // Arbitrary value.
) (
   // System clock and power-up reset.
   input  wire logic                 clk_i,
   input  wire logic                 resetn_i,
   // Test port pins.
   input  wire logic                 tck_i,
   input  wire logic                 tms_i,
   input  wire logic                 tdi_i,
   output logic                      tdo_o,
   output logic                      tdo_oe_n_o,
   // Memory pin ring.
   input  wire logic [`BSR_LEN-1:0]  pin_ring_i,
   output logic [`BSR_LEN-1:0]       bsr_drive_o,
   output logic                      extest_o,
   output logic                      q_oe_o
);

   sram_tap_pkg::tap_regs_t r_reg;
   sram_tap_pkg::tap_regs_t r_next;

   // Edge strobes, settled pin levels and register selects.
   logic [2:0] agree;
   logic       tck_rise;
   logic       tck_fall;
   logic       tms_s;
   logic       tdi_s;
   logic       sel_bsr;
   logic       sel_id;

   // Standard sixteen-state controller transition table; every state has
   // exactly one successor for each mode-select level.
   function automatic sram_tap_pkg::tap_state_t next_state(
      input sram_tap_pkg::tap_state_t st,
      input logic                     tms
   );
      sram_tap_pkg::tap_state_t ns;
      begin
         ns = sram_tap_pkg::ST_RESET;
         case (st)
            // Reset and idle.
            sram_tap_pkg::ST_RESET:
            begin
               if (tms)
                  ns = sram_tap_pkg::ST_RESET;
               else
                  ns = sram_tap_pkg::ST_IDLE;
            end
            sram_tap_pkg::ST_IDLE:
            begin
               if (tms)
                  ns = sram_tap_pkg::ST_SEL_DR;
               else
                  ns = sram_tap_pkg::ST_IDLE;
            end
            // Data register column.
            sram_tap_pkg::ST_SEL_DR:
            begin
               if (tms)
                  ns = sram_tap_pkg::ST_SEL_IR;
               else
                  ns = sram_tap_pkg::ST_CAP_DR;
            end
            sram_tap_pkg::ST_CAP_DR:
            begin
               if (tms)
                  ns = sram_tap_pkg::ST_EXIT1_DR;
               else
                  ns = sram_tap_pkg::ST_SHIFT_DR;
            end
            sram_tap_pkg::ST_SHIFT_DR:
            begin
               if (tms)
                  ns = sram_tap_pkg::ST_EXIT1_DR;
               else
                  ns = sram_tap_pkg::ST_SHIFT_DR;
            end
            sram_tap_pkg::ST_EXIT1_DR:
            begin
               if (tms)
                  ns = sram_tap_pkg::ST_UPD_DR;
               else
                  ns = sram_tap_pkg::ST_PAUSE_DR;
            end
            sram_tap_pkg::ST_PAUSE_DR:
            begin
               if (tms)
                  ns = sram_tap_pkg::ST_EXIT2_DR;
               else
                  ns = sram_tap_pkg::ST_PAUSE_DR;
            end
            sram_tap_pkg::ST_EXIT2_DR:
            begin
               if (tms)
                  ns = sram_tap_pkg::ST_UPD_DR;
               else
                  ns = sram_tap_pkg::ST_SHIFT_DR;
            end
            sram_tap_pkg::ST_UPD_DR:
            begin
               if (tms)
                  ns = sram_tap_pkg::ST_SEL_DR;
               else
                  ns = sram_tap_pkg::ST_IDLE;
            end
            // Instruction register column.
            sram_tap_pkg::ST_SEL_IR:
            begin
               if (tms)
                  ns = sram_tap_pkg::ST_RESET;
               else
                  ns = sram_tap_pkg::ST_CAP_IR;
            end
            sram_tap_pkg::ST_CAP_IR:
            begin
               if (tms)
                  ns = sram_tap_pkg::ST_EXIT1_IR;
               else
                  ns = sram_tap_pkg::ST_SHIFT_IR;
            end
            sram_tap_pkg::ST_SHIFT_IR:
            begin
               if (tms)
                  ns = sram_tap_pkg::ST_EXIT1_IR;
               else
                  ns = sram_tap_pkg::ST_SHIFT_IR;
            end
            sram_tap_pkg::ST_EXIT1_IR:
            begin
               if (tms)
                  ns = sram_tap_pkg::ST_UPD_IR;
               else
                  ns = sram_tap_pkg::ST_PAUSE_IR;
            end
            sram_tap_pkg::ST_PAUSE_IR:
            begin
               if (tms)
                  ns = sram_tap_pkg::ST_EXIT2_IR;
               else
                  ns = sram_tap_pkg::ST_PAUSE_IR;
            end
            sram_tap_pkg::ST_EXIT2_IR:
            begin
               if (tms)
                  ns = sram_tap_pkg::ST_UPD_IR;
               else
                  ns = sram_tap_pkg::ST_SHIFT_IR;
            end
            sram_tap_pkg::ST_UPD_IR:
            begin
               if (tms)
                  ns = sram_tap_pkg::ST_SEL_DR;
               else
                  ns = sram_tap_pkg::ST_IDLE;
            end
            default:
               ns = sram_tap_pkg::ST_RESET;
         endcase
         return ns;
      end
   endfunction

   // A pin level is accepted once the second and third stages agree, which
   // rejects a single-cycle glitch on the slow test clock.
   // The price is latency: an edge is seen three to four system clocks
   // late, so each test clock phase must last at least three of them.
   always_comb
   begin
      agree    = ~(r_reg.sy2 ^ r_reg.sy3);
      tck_rise = agree[`PIN_TCK] & r_reg.sy3[`PIN_TCK]
                 & ~r_reg.lvl[`PIN_TCK];
      tck_fall = agree[`PIN_TCK] & ~r_reg.sy3[`PIN_TCK]
                 & r_reg.lvl[`PIN_TCK];
      // Mode select and data in are taken as settled at the tck rise.
      tms_s    = r_reg.lvl[`PIN_TMS];
      tdi_s    = r_reg.lvl[`PIN_TDI];
   end

   // Register selection from the current instruction; the unused codes fall
   // back to the bypass bit so the chain never breaks.
   always_comb
   begin
      sel_bsr = (r_reg.ir == `INS_EXTEST)  ||
                (r_reg.ir == `INS_SAMPLE)  ||
                (r_reg.ir == `INS_SAMPLEZ);
      sel_id  = (r_reg.ir == `INS_IDCODE);
   end

   // Next state of the whole port.
   always_comb
   begin
      r_next     = r_reg;
      r_next.sy1 = {tck_i, tms_i, tdi_i};
      r_next.sy2 = r_reg.sy1;
      r_next.sy3 = r_reg.sy2;
      r_next.lvl = (r_reg.lvl & ~agree) | (r_reg.sy3 & agree);

      // Rising test clock edge: sample and act on the current state.
      if (tck_rise)
      begin
         case (r_reg.st)
            sram_tap_pkg::ST_CAP_IR:
               r_next.ir_sh = `IR_CAPTURE;
            sram_tap_pkg::ST_SHIFT_IR:
               r_next.ir_sh = {tdi_s, r_reg.ir_sh[`IR_LEN-1:1]};
            sram_tap_pkg::ST_UPD_IR:
               r_next.ir = r_reg.ir_sh;
            sram_tap_pkg::ST_CAP_DR:
            begin
               if (sel_bsr)
               begin
                  // Reserved ball cells capture zero, so a scan of the
                  // chain shows which positions are real pins.
                  r_next.bsr_sh = pin_ring_i & ~`BSR_NC_MASK;
               end
               else if (sel_id)
               begin
                  r_next.id_sh = ID_VALUE;
               end
               else
               begin
                  r_next.byp = 1'b0;
               end
            end
            sram_tap_pkg::ST_SHIFT_DR:
            begin
               // Only the selected register moves.
               if (sel_bsr)
               begin
                  r_next.bsr_sh = {tdi_s,
                                   r_reg.bsr_sh[`BSR_LEN-1:1]};
               end
               else if (sel_id)
               begin
                  r_next.id_sh = {tdi_s, r_reg.id_sh[`ID_LEN-1:1]};
               end
               else
               begin
                  r_next.byp = tdi_s;
               end
            end
            sram_tap_pkg::ST_UPD_DR:
            begin
               // Preload only under the two preload instructions.
               if ((r_reg.ir == `INS_SAMPLE) || (r_reg.ir == `INS_EXTEST))
               begin
                  r_next.bsr_upd = r_reg.bsr_sh;
               end
            end
            default:
            begin
               r_next.st = r_reg.st;
            end
         endcase
         r_next.st = next_state(r_reg.st, tms_s);
         // Whatever path leads into reset, the identification instruction
         // and the bus enable preset hold from that very rise, so the
         // memory bus is never left floated by a stale instruction.
         if (r_next.st == sram_tap_pkg::ST_RESET)
         begin
            r_next.ir                    = `INS_IDCODE;
            r_next.bsr_upd[`BSR_OE_CELL] = 1'b1;
         end
      end

      // Falling edge: present the LSB of the selected register.
      // Data out is registered, so it settles three to four system clocks
      // after the pin falls; read it late in the low phase.
      if (tck_fall)
      begin
         if ((r_reg.st == sram_tap_pkg::ST_SHIFT_IR) ||
             (r_reg.st == sram_tap_pkg::ST_SHIFT_DR))
         begin
            r_next.tdo_oe_n = 1'b0;
         end
         else
         begin
            r_next.tdo_oe_n = 1'b1;
         end
         if (r_reg.st == sram_tap_pkg::ST_SHIFT_IR)
         begin
            r_next.tdo = r_reg.ir_sh[0];
         end
         else if (sel_bsr)
         begin
            r_next.tdo = r_reg.bsr_sh[0];
         end
         else if (sel_id)
         begin
            r_next.tdo = r_reg.id_sh[0];
         end
         else
         begin
            r_next.tdo = r_reg.byp;
         end
      end

      // Output bus control follows the instruction that is about to hold.
      // Working from the next copy keeps q_oe_o in step with extest_o.
      r_next.ext  = (r_next.ir == `INS_EXTEST);
      r_next.q_oe = (r_next.ir != `INS_SAMPLEZ) &&
                    !(r_next.ext &&
                      !r_next.bsr_upd[`BSR_OE_CELL]);
   end

   // Power-up reset; the test port itself never resets the memory, it only
   // drives the pins through extest_o and bsr_drive_o and gates the output bus
   // through q_oe_o.
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         r_reg          <= '0;
         r_reg.sy1      <= `PIN_RESET;
         r_reg.sy2      <= `PIN_RESET;
         r_reg.sy3      <= `PIN_RESET;
         r_reg.lvl      <= `PIN_RESET;
         r_reg.st       <= sram_tap_pkg::ST_RESET;
         r_reg.ir       <= `INS_IDCODE;
         r_reg.ir_sh    <= `IR_CAPTURE;
         r_reg.bsr_upd  <= `BSR_LEN'h1 << `BSR_OE_CELL;
         r_reg.byp      <= 1'b0;
         r_reg.tdo_oe_n <= 1'b1;
         r_reg.q_oe     <= 1'b1;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   // Every output straight from a flip-flop.
   assign tdo_o       = r_reg.tdo;
   assign tdo_oe_n_o  = r_reg.tdo_oe_n;
   assign bsr_drive_o = r_reg.bsr_upd;
   assign extest_o    = r_reg.ext;
   assign q_oe_o      = r_reg.q_oe;

endmodule // sram_boundary_scan_tap

`default_nettype wire

/* inc/sram_tap_cfg.svh */
`ifndef SRAM_TAP_CFG_SVH
`define SRAM_TAP_CFG_SVH

// Scan chain geometry.
`define BSR_LEN      64
`define BSR_OE_CELL  47
`define BSR_NC_MASK  64'hf000_0000_0000_0000
`define IR_LEN       3
`define ID_LEN       32

// Instruction codes.
`define INS_EXTEST   3'h0
`define INS_IDCODE   3'h1
`define INS_SAMPLEZ  3'h2
`define INS_RSVD_A   3'h3
`define INS_SAMPLE   3'h4
`define INS_RSVD_B   3'h5
`define INS_RSVD_C   3'h6
`define INS_BYPASS   3'h7

// Capture pattern of the instruction register.
`define IR_CAPTURE   3'h1

// Pin bit positions inside the synchroniser vectors.
`define PIN_TCK      2
`define PIN_TMS      1
`define PIN_TDI      0
`define PIN_RESET    3'h3

`endif

/* inc/sram_tap_pkg.sv */
`include "sram_tap_cfg.svh"
`default_nettype none

package sram_tap_pkg;

   // Port controller states.
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE,
      ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
      ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
      ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
      ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
   } tap_state_t;

   // Whole state of the port.
   typedef struct packed {
      logic [2:0]               sy1;
      logic [2:0]               sy2;
      logic [2:0]               sy3;
      logic [2:0]               lvl;
      tap_state_t               st;
      logic [`IR_LEN-1:0]       ir_sh;
      logic [`IR_LEN-1:0]       ir;
      logic [`BSR_LEN-1:0]      bsr_sh;
      logic [`BSR_LEN-1:0]      bsr_upd;
      logic [`ID_LEN-1:0]       id_sh;
      logic                     byp;
      logic                     tdo;
      logic                     tdo_oe_n;
      logic                     ext;
      logic                     q_oe;
   } tap_regs_t;

endpackage

`default_nettype wire

/* testbench/sram_tap_asserts.sv */
`include "sram_tap_cfg.svh"
`default_nettype none

module sram_tap_asserts (
   // Clock and reset.
   input wire logic                clk_i,
   input wire logic                resetn_i,
   // Watched pins.
   input wire logic                tck_i,
   input wire logic                tms_i,
   input wire logic                tdo_o,
   input wire logic                tdo_oe_n_o,
   input wire logic [`BSR_LEN-1:0] bsr_drive_o,
   input wire logic                extest_o,
   input wire logic                q_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   logic [2:0] tck_reg;
   logic [2:0] tms_reg;
   logic [2:0] ones_reg;

   // Counts consecutive test clock rises taken with mode select high; a low rise clears it; it saturates.
   always_ff @(posedge clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         tck_reg  <= 3'h0;
         tms_reg  <= 3'h7;
         ones_reg <= 3'h0;
      end
      else
      begin
         tck_reg <= {tck_reg[1:0], tck_i};
         tms_reg <= {tms_reg[1:0], tms_i};
         if (tck_reg[1] && !tck_reg[2])
            ones_reg <= !tms_reg[1] ? 3'h0 : (ones_reg == 3'h7) ? 3'h7
                        : ones_reg + 3'h1;
      end

   // Outputs are checked against reset values, test clock phases, cell 47 and the mode select count with the exact figures.
   AST_RESET_VALUES: assert property ($rose(resetn_i) |-> tdo_oe_n_o
      && q_oe_o && !extest_o && bsr_drive_o == 64'h0000_8000_0000_0000)
      else $error("port not in reset state after power up");
   AST_OE_ON_FALL: assert property ($changed(tdo_oe_n_o) |-> !tck_i
      && !$past(tck_i, 3)) else $error("data out enable moved off a fall");
   AST_TDO_ON_FALL: assert property ($changed(tdo_o) |-> !tck_i ##1
      !tck_i) else $error("data out moved off a fall");
   AST_DRIVE_ON_RISE: assert property ($changed(bsr_drive_o) |-> tck_i
      && $past(tck_i, 3)) else $error("preload moved off a rise");
   AST_EXTEST_ON_RISE: assert property ($changed(extest_o) |->
      $past(tck_i, 3) ##1 tck_i) else $error("instruction moved off a rise");
   AST_OE_CELL: assert property (extest_o && $past(extest_o, 2)
      && bsr_drive_o[47] == $past(bsr_drive_o[47], 2)
      |-> q_oe_o == bsr_drive_o[47]) else $error("bus enable not cell 47");
   AST_TMS_RESET: assert property (ones_reg == 3'h5
      && $past(ones_reg) == 3'h4 |-> ##[0:6]
      (!extest_o && q_oe_o && bsr_drive_o[47]))
      else $error("no test logic reset after five rises");
   AST_FLOAT_OUT_SHIFT: assert property (ones_reg >= 3'h2 |->
      tdo_oe_n_o) else $error("data out driven outside shift");
   cover property ($rose(extest_o));
   cover property ($fell(tdo_oe_n_o));
   cover property (ones_reg == 3'h5);
endmodule // sram_tap_asserts

bind sram_boundary_scan_tap sram_tap_asserts u_chk (.clk_i(clk_i),
   .resetn_i(resetn_i), .tck_i(tck_i), .tms_i(tms_i), .tdo_o(tdo_o),
   .tdo_oe_n_o(tdo_oe_n_o), .bsr_drive_o(bsr_drive_o),
   .extest_o(extest_o), .q_oe_o(q_oe_o));

`default_nettype wire

/* testbench/tap_ctl_model.sv */
`default_nettype none

module tap_ctl_model (
   // Test port pins toward the memory.
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o,
   input  wire logic tdo_i,
   input  wire logic tdo_oe_n_i
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [63:0] dout;

   // The test clock rests low between frames so no edge is seen.
   initial
   begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
   end

   // One 160 ns period; data out is read late in the low phase, and a
   // floating line reads as z so it never passes for data.
   task automatic step(input logic t, input logic d, output logic q);
      tms_o = t;
      tdi_o = d;
      #40;
      q = tdo_oe_n_i ? 1'bz : tdo_i;
      tck_o = 1'b1;
      #80;
      tck_o = 1'b0;
      #40;
   endtask

   // Five rises with mode select high, then park in idle.
   task automatic tlr;
      logic q;
      repeat (5) step(1'b1, ~tdi_o, q);
      step(1'b0, ~tdi_o, q);
   endtask

   // Idle to idle scan of n bits, low bit first; only implemented
   // instruction codes are ever handed in.
   task automatic scan(input logic ir, input int n, input logic [63:0] din);
      logic q;
      step(1'b1, ~tdi_o, q);
      if (ir)
         step(1'b1, ~tdi_o, q);
      step(1'b0, ~tdi_o, q);
      step(1'b0, ~tdi_o, q);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, ~tdi_o, q);
      step(1'b0, ~tdi_o, q);
   endtask
endmodule // tap_ctl_model

`default_nettype wire

/* testbench/tb_top.sv */
`include "sram_tap_cfg.svh"
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] ID_VAL = 32'h1234_5a01; // Arbitrary value.
   localparam logic [63:0] PINS = 64'h5a5a_c3c3_0ff0_9669;
   localparam logic [63:0] PRE = 64'h1234_0000_89ab_cdef;
   logic        clk;
   logic        resetn;
   logic        tck;
   logic        tms;
   logic        tdi;
   logic        tdo;
   logic        tdo_oe_n;
   logic [63:0] pin_ring;
   logic [63:0] bsr_drive;
   logic        extest;
   logic        q_oe;
   int          miscompares = 0;
   int          samples_checked = 0;

   sram_boundary_scan_tap #(.ID_VALUE(ID_VAL)) DUT (.clk_i(clk),
      .resetn_i(resetn), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
      .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .pin_ring_i(pin_ring),
      .bsr_drive_o(bsr_drive), .extest_o(extest), .q_oe_o(q_oe));
   tap_ctl_model ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
      .tdo_oe_n_i(tdo_oe_n));

   // System clock at 200 MHz.
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Compares and counts; case inequality lets no unknown pass.
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the verdict and ends the run.
   task automatic wrap_up;
      if (miscompares == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Loads an instruction; the captured pattern comes back out.
   task automatic load_ir(input logic [2:0] code);
      ctl.scan(1'b1, 3, {61'h0, code});
      check(ctl.dout[2:0], 3'h1);
   endtask

   // Power-up state before any test clock.
   task automatic t_power_up;
      check({tdo_oe_n, extest, q_oe}, 3'h5);
      check(bsr_drive, 64'h0000_8000_0000_0000);
   endtask

   // Identification read; data out floats once shifting ends.
   task automatic t_idcode;
      ctl.scan(1'b0, 32, 64'h0);
      check(ctl.dout[31:0], ID_VAL);
      check(tdo_oe_n, 1'b1);
   endtask

   // Sample and preload: snapshot out, preload with cell 47 low in.
   task automatic t_sample;
      @(negedge clk) pin_ring = PINS;
      load_ir(`INS_SAMPLE);
      ctl.scan(1'b0, 64, PRE);
      check(ctl.dout, PINS & ~`BSR_NC_MASK);
      check(bsr_drive, PRE);
      check({extest, q_oe}, 2'h1);
   endtask

   // External test drives the preload; cell 47 low floats the bus,
   // and a test logic reset presets it high again.
   task automatic t_extest_reset;
      load_ir(`INS_EXTEST);
      check({extest, q_oe}, 2'h2);
      check(bsr_drive, PRE);
      ctl.tlr();
      check({extest, q_oe, bsr_drive[47]}, 3'h3);
   endtask

   // Floated sample keeps the bus off until bypass replaces it.
   task automatic t_samplez_bypass;
      @(negedge clk) pin_ring = ~PINS;
      load_ir(`INS_SAMPLEZ);
      check({extest, q_oe}, 2'h0);
      ctl.scan(1'b0, 64, 64'h0);
      check(ctl.dout, ~PINS & ~`BSR_NC_MASK);
      load_ir(`INS_BYPASS);
      check(q_oe, 1'b1);
      ctl.scan(1'b0, 8, 64'ha5);
      check(ctl.dout[7:0], 8'h4a);
   endtask

   // A power-up reset in mid-run restores the test logic reset state and the
   // identification instruction without any test clock.
   task automatic t_mid_reset;
      logic q;
      load_ir(`INS_SAMPLEZ);
      check(q_oe, 1'b0);
      @(negedge clk) resetn = 1'b0;
      repeat (5) @(negedge clk);
      resetn = 1'b1;
      check({tdo_oe_n, extest, q_oe}, 3'h5);
      check(bsr_drive, 64'h0000_8000_0000_0000);
      ctl.step(1'b0, 1'b1, q);
      ctl.scan(1'b0, 32, 64'h0);
      check(ctl.dout[31:0], ID_VAL);
   endtask

   // Main sequence.
   initial
   begin
      resetn = 1'b0;
      pin_ring = 64'h0;
      repeat (5) @(posedge clk);
      @(negedge clk) resetn = 1'b1;
      t_power_up();
      ctl.tlr();
      t_idcode();
      t_sample();
      t_extest_reset();
      t_idcode();
      t_samplez_bypass();
      t_mid_reset();
      wrap_up();
   end

   // Cuts a hang short after about six times the expected run.
   initial
   begin
      #300000;
      miscompares++;
      wrap_up();
   end
endmodule // tb_top

`default_nettype wire
